/* File: common/ppc_params.svh */
`ifndef PPC_PARAMS_SVH
`define PPC_PARAMS_SVH
// Register addresses in the special-function space, the same on every page.
`define PPC_ADDR_P2_DATA      8'ha0
`define PPC_ADDR_P1_DRVMODE   8'ha5
`define PPC_ADDR_P1_BYPASS    8'hd5
`define PPC_ADDR_P1_ANALOG    8'hf2
`define PPC_ADDR_P2_ANALOG    8'hf3
// Bit address of bit 0 of the second port's data register.
`define PPC_BITADDR_P2_BASE   8'ha0
// Reset values.
`define PPC_RST_P2_DATA       5'h1f
`define PPC_RST_P1_DRVMODE    8'h00
`define PPC_RST_P1_BYPASS     8'h00
`define PPC_RST_P1_ANALOG     8'hff
`define PPC_RST_P2_ANALOG     4'hf
// Field widths.
`define PPC_P1_WIDTH          8
`define PPC_P2_WIDTH          5
`define PPC_P2_ANALOG_WIDTH   4
`endif

/* File: common/ppc_pkg.sv */
package ppc_pkg;
    typedef logic [7:0] ppc_byte_t;
    // Register selected by an access.
    typedef enum logic [2:0] {
        PPC_SEL_NONE,
        PPC_SEL_P2_DATA,
        PPC_SEL_P1_DRVMODE,
        PPC_SEL_P1_BYPASS,
        PPC_SEL_P1_ANALOG,
        PPC_SEL_P2_ANALOG
    } ppc_sel_t;
endpackage

/* File: src/ppc_port_config.sv */
`include "ppc_params.svh"
// Behaviour
// [RULE_01] First port drive bit: one push-pull, zero open-drain.
// [RULE_02] Drive bit ignored while pin is analog.
// [RULE_03] First port bypass bit removes pin from crossbar.
// [RULE_04] Software should bypass analog, special, GPIO pins.
// [RULE_05] Second port data write loads output latch.
// [RULE_06] Second port data read returns pin level.
// [RULE_07] Second port analog register bits 7:4 read zero.
// [RULE_08] Second port analog bit zero means analog mode.
// [RULE_09] Analog pin: pullup, driver, receiver all off.
// [RULE_10] Second port data bit-addressable, on every page.
// [RULE_11] First port analog bit zero means analog mode.
// [RULE_12] Open-drain high latch releases the pin.
module ppc_port_config #(
    parameter int P1W = `PPC_P1_WIDTH,
    parameter int P2W = `PPC_P2_WIDTH
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [7:0]       sfrAddr,
    input  wire logic [7:0]       sfrWrData,
    input  wire logic             sfrWr,
    input  wire logic             sfrRd,
    output logic      [7:0]       sfrRdData,
    input  wire logic [7:0]       bitAddr,
    input  wire logic             bitValue,
    input  wire logic             bitWr,
    input  wire logic [P2W-1:0]   p2PushPull,
    input  wire logic [P2W-1:0]   p2PinIn,
    output logic      [P2W-1:0]   p2PinOut,
    output logic      [P2W-1:0]   p2PinOe_n,
    output logic      [P2W-1:0]   p2PullupEn,
    output logic      [P2W-1:0]   p2ReceiverEn,
    output logic      [P1W-1:0]   p1PushPullEff,
    output logic      [P1W-1:0]   p1DigitalEn,
    output logic      [P1W-1:0]   p1CrossbarSkip
);
    // ****************************************************************
    // Elaboration check
    // ****************************************************************
    // Refuses widths that the fixed register layout cannot serve.
    if (P1W != 8 || P2W != 5) begin
        $error("Port widths are fixed by the register layout.");
    end

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Maps an address to its register; the page is not decoded, so every
    // register answers on every page.
    function automatic ppc_pkg::ppc_sel_t decodeSel(input logic [7:0] a);
        unique case (a)
            `PPC_ADDR_P2_DATA:    decodeSel = ppc_pkg::PPC_SEL_P2_DATA;
            `PPC_ADDR_P1_DRVMODE: decodeSel = ppc_pkg::PPC_SEL_P1_DRVMODE;
            `PPC_ADDR_P1_BYPASS:  decodeSel = ppc_pkg::PPC_SEL_P1_BYPASS;
            `PPC_ADDR_P1_ANALOG:  decodeSel = ppc_pkg::PPC_SEL_P1_ANALOG;
            `PPC_ADDR_P2_ANALOG:  decodeSel = ppc_pkg::PPC_SEL_P2_ANALOG;
            default:              decodeSel = ppc_pkg::PPC_SEL_NONE;
        endcase
    endfunction

    localparam logic [7:0] BIT_BASE = `PPC_BITADDR_P2_BASE;

    ppc_pkg::ppc_sel_t sel;
    logic              bitHit;
    logic [2:0]        bitIdx;
    assign sel    = decodeSel(sfrAddr); // RULE_10
    assign bitIdx = bitAddr[2:0];
    // Only the five implemented latch bits answer; the upper bit slots are refused.
    assign bitHit = bitWr && (bitAddr[7:3] == BIT_BASE[7:3])
                    && (bitIdx < 3'h5); // RULE_10

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [P1W-1:0] p1DriveMode_r;
    logic [P1W-1:0] p1Bypass_r;
    logic [P1W-1:0] p1AnalogSel_r;
    logic [P2W-1:0] p2Latch_r;
    logic [P2W-1:0] p2Latch_nxt;
    logic [3:0]     p2AnalogSel_r;

    // Bit writes land after a byte write in the same cycle, so they win.
    always_comb begin
        p2Latch_nxt = p2Latch_r;
        if (sfrWr && sel == ppc_pkg::PPC_SEL_P2_DATA) begin
            p2Latch_nxt = sfrWrData[P2W-1:0]; // RULE_05
        end
        if (bitHit) begin
            p2Latch_nxt[bitIdx] = bitValue; // RULE_10
        end
    end

    // Holds the software-written configuration.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            p1DriveMode_r <= `PPC_RST_P1_DRVMODE;
            p1Bypass_r    <= `PPC_RST_P1_BYPASS;
            p1AnalogSel_r <= `PPC_RST_P1_ANALOG;
            p2Latch_r     <= `PPC_RST_P2_DATA;
            p2AnalogSel_r <= `PPC_RST_P2_ANALOG;
        end else begin
            p2Latch_r <= p2Latch_nxt;
            if (sfrWr && sel == ppc_pkg::PPC_SEL_P1_DRVMODE) begin
                p1DriveMode_r <= sfrWrData; // RULE_01
            end
            if (sfrWr && sel == ppc_pkg::PPC_SEL_P1_BYPASS) begin
                p1Bypass_r <= sfrWrData; // RULE_03
            end
            if (sfrWr && sel == ppc_pkg::PPC_SEL_P1_ANALOG) begin
                p1AnalogSel_r <= sfrWrData; // RULE_11
            end
            if (sfrWr && sel == ppc_pkg::PPC_SEL_P2_ANALOG) begin
                p2AnalogSel_r <= sfrWrData[3:0]; // RULE_07
            end
        end
    end

    // ****************************************************************
    // Pin synchroniser
    // ****************************************************************
    logic [P2W-1:0] p2PinMeta_r;
    logic [P2W-1:0] p2PinSync_r;

    // Two flops guard against metastability on the asynchronous pins.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            p2PinMeta_r <= '0;
            p2PinSync_r <= '0;
        end else begin
            p2PinMeta_r <= p2PinIn;
            p2PinSync_r <= p2PinMeta_r;
        end
    end

    // ****************************************************************
    // Pin control
    // ****************************************************************
    logic [P2W-1:0] p2Digital;
    logic [P2W-1:0] p2Drive;
    logic [P2W-1:0] p2PinLevel;
    logic [P1W-1:0] p1PushPullNxt;
    // Pin 4 has no analog option and is always digital.
    assign p2Digital     = {1'b1, p2AnalogSel_r}; // RULE_08
    // Drive when digital and either push-pull or pulling low.
    assign p2Drive       = p2Digital & (p2PushPull | ~p2Latch_nxt); // RULE_09 RULE_12
    // A pin with its receiver off reads low.
    assign p2PinLevel    = p2PinSync_r & p2Digital; // RULE_06 RULE_09
    assign p1PushPullNxt = p1DriveMode_r & p1AnalogSel_r; // RULE_01 RULE_02

    // Registers every pin control output.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            p2PinOut       <= `PPC_RST_P2_DATA;
            p2PinOe_n      <= '1;
            p2PullupEn     <= '0;
            p2ReceiverEn   <= '0;
            p1PushPullEff  <= '0;
            p1DigitalEn    <= '0;
            p1CrossbarSkip <= '0;
        end else begin
            p2PinOut       <= p2Latch_nxt; // RULE_05
            p2PinOe_n      <= ~p2Drive; // RULE_09 RULE_12
            p2PullupEn     <= p2Digital; // RULE_09
            p2ReceiverEn   <= p2Digital; // RULE_09
            p1PushPullEff  <= p1PushPullNxt; // RULE_02
            p1DigitalEn    <= p1AnalogSel_r; // RULE_11
            p1CrossbarSkip <= p1Bypass_r; // RULE_03
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [7:0] rdMux;
    assign rdMux = (sel == ppc_pkg::PPC_SEL_P2_DATA)    ? {3'h0, p2PinLevel} : // RULE_06
                   (sel == ppc_pkg::PPC_SEL_P1_DRVMODE) ? p1DriveMode_r :
                   (sel == ppc_pkg::PPC_SEL_P1_BYPASS)  ? p1Bypass_r :
                   (sel == ppc_pkg::PPC_SEL_P1_ANALOG)  ? p1AnalogSel_r :
                   (sel == ppc_pkg::PPC_SEL_P2_ANALOG)  ? {4'h0, p2AnalogSel_r} : // RULE_07
                   8'h00;

    // Read data appears the cycle after the read strobe and holds.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sfrRdData <= 8'h00;
        end else if (sfrRd) begin
            sfrRdData <= rdMux;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_rd_pin;
        sfrRd && sfrAddr == 8'ha0 |=> sfrRdData == {3'h0, $past(p2PinSync_r & p2Digital)};
    endproperty
    a_rd_pin: assert property (p_rd_pin) else $error("Port data read wrong."); // RULE_06

    property p_wr_latch;
        sfrWr && sfrAddr == 8'ha0 && !bitWr |=> p2PinOut == $past(sfrWrData[4:0]);
    endproperty
    a_wr_latch: assert property (p_wr_latch) else $error("Latch not loaded."); // RULE_05

    property p_bit_wr;
        bitWr && bitAddr == 8'ha2 |=> p2PinOut[2] == $past(bitValue);
    endproperty
    a_bit_wr: assert property (p_bit_wr) else $error("Bit write lost."); // RULE_10

    property p_mdin_upper;
        sfrRd && sfrAddr == 8'hf3 |=> sfrRdData[7:4] == 4'h0;
    endproperty
    a_mdin_upper: assert property (p_mdin_upper) else $error("Upper bits not zero."); // RULE_07

    property p_analog_off;
        sfrWr && sfrAddr == 8'hf3 && !sfrWrData[0] |=> ##1
            (p2PinOe_n[0] && !p2PullupEn[0] && !p2ReceiverEn[0]);
    endproperty
    a_analog_off: assert property (p_analog_off) else $error("Analog pin active."); // RULE_09

    property p_od_release;
        !p2PushPull[0] && p2PinOut[0] && $stable(p2PushPull[0]) ##1 $stable(p2PinOut[0])
            |-> p2PinOe_n[0];
    endproperty
    a_od_release: assert property (p_od_release) else $error("Open drain drives."); // RULE_12

    property p_p1_mode;
        sfrWr && sfrAddr == 8'hf2 |=> ##1 (p1PushPullEff & ~$past(sfrWrData, 2)) == 8'h00;
    endproperty
    a_p1_mode: assert property (p_p1_mode) else $error("Analog pin push-pull."); // RULE_02

    property p_p1_pp;
        sfrWr && sfrAddr == 8'ha5 && sfrWrData[5] && p1AnalogSel_r[5]
            && !(sfrAddr == 8'hf2) |=> ##1 p1PushPullEff[5] || !$past(p1AnalogSel_r[5]);
    endproperty
    a_p1_pp: assert property (p_p1_pp) else $error("Push-pull not set."); // RULE_01

    property p_skip;
        sfrWr && sfrAddr == 8'hd5 |=> ##1 p1CrossbarSkip == $past(sfrWrData, 2);
    endproperty
    a_skip: assert property (p_skip) else $error("Skip not applied."); // RULE_03

    property p_p1_digital;
        sfrWr && sfrAddr == 8'hf2 |=> ##1 p1DigitalEn == $past(sfrWrData, 2);
    endproperty
    a_p1_digital: assert property (p_p1_digital) else $error("Input mode wrong."); // RULE_11

    c_bit_wr: cover property (bitWr && bitAddr == 8'ha4);
    c_analog: cover property (sfrWr && sfrAddr == 8'hf3 && sfrWrData[3:0] == 4'h0);
    c_rd_pin: cover property (sfrRd && sfrAddr == 8'ha0);
endmodule

/* File: verif/ppc_pin_model.sv */
// ****************************************
// Pin and board model of the second port
// ****************************************
module ppc_pin_model (
    input  wire logic       sys_clk,
    input  wire logic [4:0] pinOut,
    input  wire logic [4:0] pinOe_n,
    input  wire logic [4:0] pullupEn,
    input  wire logic [4:0] extEn,
    input  wire logic [4:0] extVal,
    output logic      [4:0] pinLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    logic toggle_r = 1'b0;
    // A floating pin shows a changing level so that it never reads as a clean value.
    always @(posedge sys_clk) begin
        toggle_r <= ~toggle_r;
    end
    // The device drive wins, then the board drive, then the weak pullup.
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (!pinOe_n[i]) pinLevel[i] = pinOut[i];
            else if (extEn[i]) pinLevel[i] = extVal[i];
            else if (pullupEn[i]) pinLevel[i] = 1'b1;
            else pinLevel[i] = toggle_r ^ i[0];
        end
    end
endmodule

/* File: verif/port_pin_config_regs_tb.sv */
// ****************************************
// Register and pin checks of the port block
// ****************************************
module port_pin_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk = 1'b0, rst = 1'b1, sfrWr = 1'b0, sfrRd = 1'b0;
    logic       bitValue = 1'b0, bitWr = 1'b0;
    logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, bitAddr = 8'h00, sfrRdData;
    logic [4:0] p2PushPull = 5'h00, extEn = 5'h00, extVal = 5'h00;
    logic [4:0] p2PinIn, p2PinOut, p2PinOe_n, p2PullupEn, p2ReceiverEn;
    logic [7:0] p1PushPullEff, p1DigitalEn, p1CrossbarSkip;
    int         n_fail = 0, compares = 0;
    // The clock runs at 25 MHz.
    always #20 sys_clk = ~sys_clk;
    ppc_port_config dut (.sys_clk(sys_clk), .rst(rst), .sfrAddr(sfrAddr),
        .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData(sfrRdData),
        .bitAddr(bitAddr), .bitValue(bitValue), .bitWr(bitWr), .p2PushPull(p2PushPull),
        .p2PinIn(p2PinIn), .p2PinOut(p2PinOut), .p2PinOe_n(p2PinOe_n),
        .p2PullupEn(p2PullupEn), .p2ReceiverEn(p2ReceiverEn),
        .p1PushPullEff(p1PushPullEff), .p1DigitalEn(p1DigitalEn),
        .p1CrossbarSkip(p1CrossbarSkip));
    ppc_pin_model pins (.sys_clk(sys_clk), .pinOut(p2PinOut), .pinOe_n(p2PinOe_n),
        .pullupEn(p2PullupEn), .extEn(extEn), .extVal(extVal), .pinLevel(p2PinIn));
    // Compares one byte and reports a mismatch at once.
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Byte write, held for one taking edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfrWr <= 1'b1;
        sfrAddr <= a;
        sfrWrData <= d;
        @(posedge sys_clk);
        sfrWr <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Byte read, checked once the registered answer has landed.
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        sfrRd <= 1'b1;
        sfrAddr <= a;
        @(posedge sys_clk);
        sfrRd <= 1'b0;
        @(posedge sys_clk);
        #1 chk($sformatf("read %h", a), exp, sfrRdData);
        @(posedge sys_clk);
    endtask
    // Single bit write into the second port latch.
    task automatic bw(input logic [7:0] a, input logic v);
        bitWr <= 1'b1;
        bitAddr <= a;
        bitValue <= v;
        @(posedge sys_clk);
        bitWr <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Lets configuration and pin synchronisers settle, leaving off the edge.
    task automatic settle();
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // The watchdog cuts a hung run short.
    initial begin
        repeat (3000) @(posedge sys_clk);
        n_fail++;
        print_verdict();
    end
    // Test sequence.
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        settle();
        chk("digitalEn", 8'hff, p1DigitalEn);
        chk("pushPullEff", 8'h00, p1PushPullEff);
        chk("skip", 8'h00, p1CrossbarSkip);
        chk("pinOe", 8'h1f, {3'h0, p2PinOe_n});
        chk("pullup", 8'h1f, {3'h0, p2PullupEn});
        @(posedge sys_clk);
        rdchk(8'ha0, 8'h1f);
        rdchk(8'ha5, 8'h00);
        rdchk(8'hd5, 8'h00);
        rdchk(8'hf3, 8'h0f);
        rdchk(8'hf2, 8'hff);
        rdchk(8'h33, 8'h00);
        $display("test reset done");
        wr(8'ha5, 8'hff);
        wr(8'hf2, 8'h0f);
        wr(8'hd5, 8'ha5);
        settle();
        chk("pushPullEff", 8'h0f, p1PushPullEff);
        chk("digitalEn", 8'h0f, p1DigitalEn);
        chk("skip", 8'ha5, p1CrossbarSkip);
        @(posedge sys_clk);
        rdchk(8'ha5, 8'hff);
        rdchk(8'hd5, 8'ha5);
        $display("test first port done");
        p2PushPull <= 5'h1f;
        wr(8'hf3, 8'hfe);
        wr(8'ha0, 8'h0b);
        settle();
        chk("pinOut", 8'h0b, {3'h0, p2PinOut});
        chk("pinOe", 8'h01, {3'h0, p2PinOe_n});
        chk("pullup", 8'h1e, {3'h0, p2PullupEn});
        chk("receiver", 8'h1e, {3'h0, p2ReceiverEn});
        @(posedge sys_clk);
        rdchk(8'hf3, 8'h0e);
        rdchk(8'ha0, 8'h0a);
        p2PushPull <= 5'h00;
        extEn <= 5'h04;
        wr(8'hf3, 8'h0f);
        wr(8'ha0, 8'hff);
        settle();
        chk("pinOe", 8'h1f, {3'h0, p2PinOe_n});
        @(posedge sys_clk);
        rdchk(8'ha0, 8'h1b);
        extEn <= 5'h00;
        bw(8'ha2, 1'b0);
        bw(8'ha5, 1'b0);
        settle();
        chk("pinOut", 8'h1b, {3'h0, p2PinOut});
        chk("pinOe", 8'h1b, {3'h0, p2PinOe_n});
        @(posedge sys_clk);
        rdchk(8'ha0, 8'h1b);
        $display("test second port done");
        print_verdict();
    end
endmodule
